// file: rtl/mir_i2c_regs.sv
// Contract
// - device acks matching address, then releases
// - register byte acked and loaded into pointer
// - next data byte acked and stored
// - address with read bit is acked
// - device drives register bytes, msb first
// - master nack ends sending, line released
// - pointer increments after every byte
// - each read starts at last written pointer
// - wrap from 06 to 00 on reads when enabled
// - wrap enabled by bit 6 of 0A
// - eight-bit registers, eight-bit address
// - axis low/high pairs at 00..05, read-only
// - 0B is a read/write period register
// - axis read clears ready and overrun flags
// - axis updates blocked until 05 read
// - soft reset restores all register defaults
// - 0A bit 0 disables data-ready pin
`timescale 1ns/100ps
module mir_i2c_regs (
  // core clock domain
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // link sampling clock domain
  input wire logic link_clk,
  // i2c pins, data line open drain
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // measurement samples from the sensor core
  input wire logic meas_valid,
  input wire mir_pkg::mir_meas_t meas,
  output logic meas_ready,
  // configuration and data-ready pin toward the core
  output mir_pkg::mir_cfg_t cfg,
  output logic data_ready_pin
);
  import mir_pkg::*;

  // link-domain reset and enable synchronisers
  logic lrst_s1, lrst, ce_s1, ce_l;
  logic [4:0] rst_cnt_reg;
  logic rst_long_reg;
  // pin synchronisers and edge history
  logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
  // protocol engine
  mir_state_t state_reg;
  logic [2:0] cnt_reg;
  logic [7:0] shift_reg, tx_reg;
  logic done_reg, rw_reg, master_acknowledge_reg, oe_reg;
  // pointer
  logic [7:0] ptr_reg, base_reg;
  logic win_reg;
  // register contents
  mir_cfg_t cfg_reg;
  logic wrap_en_reg;
  mir_meas_t data_reg;
  logic data_ready_flag_reg, data_overrun_flag_reg, lock_reg, irq_reg;
  // sample crossing
  mir_meas_t hold_reg;
  logic req_reg, ack_s1, ack_s2, req_s1, req_s2, req_s3;
  // config and pin crossing
  mir_cfg_t cfg_s1, cfg_s2, cfg_s3, cfg_out_reg;
  logic irq_s1, irq_s2;

  // events
  logic scl_rise, scl_fall, start_det, stop_det, rx_last;
  logic wr_evt, soft_rst, load_rd, win_now, sample_evt, axis_rd;
  logic [7:0] rd_ptr, rd_byte;

  // register read decode
  function automatic logic [7:0] mir_read(input logic [7:0] a);
    case (a)
      MIR_X_LOW: mir_read = data_reg.x_axis_field[7:0];
      MIR_X_HIGH: mir_read = data_reg.x_axis_field[15:8];
      MIR_Y_LOW: mir_read = data_reg.y_axis_field[7:0];
      MIR_Y_HIGH: mir_read = data_reg.y_axis_field[15:8];
      MIR_Z_LOW: mir_read = data_reg.z_axis_field[7:0];
      MIR_Z_HIGH: mir_read = data_reg.z_axis_field[15:8];
      MIR_STATUS: mir_read = {5'h00, data_overrun_flag_reg, data_reg.overflow_flag, data_ready_flag_reg};
      MIR_TEMP_LOW: mir_read = data_reg.temperature_value[7:0];
      MIR_TEMP_HIGH: mir_read = data_reg.temperature_value[15:8];
      MIR_MEAS_CONFIG: mir_read = {cfg_reg.oversample_ratio, cfg_reg.field_range, cfg_reg.output_rate, cfg_reg.mode};
      MIR_RESET_PTR_IRQ: mir_read = {1'b0, wrap_en_reg, 5'h00, cfg_reg.irq_pin_disable};
      MIR_SR_PERIOD: mir_read = cfg_reg.set_reset_period_value;
      default: mir_read = 8'h00;
    endcase
  endfunction : mir_read

  // next pointer after one byte
  function automatic logic [7:0] mir_next_ptr(input logic [7:0] p, input logic wrap);
    if (wrap && p == MIR_WRAP_LAST)
      mir_next_ptr = MIR_PTR_RST;
    else
      mir_next_ptr = p + 8'h01;
  endfunction : mir_next_ptr

  // rst stretched in the core domain, so a short pulse still reaches the link clock
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rst_cnt_reg <= MIR_RST_HOLD;
      rst_long_reg <= 1'b1;
    end
    else
    begin
      if (rst_cnt_reg != 5'h00)
        rst_cnt_reg <= rst_cnt_reg - 5'h01;
      rst_long_reg <= rst_cnt_reg != 5'h00;
    end
  end

  // reset and enable into the link domain; these run ungated
  always_ff @(posedge link_clk)
  begin
    lrst_s1 <= rst_long_reg;
    lrst <= lrst_s1;
    ce_s1 <= ce;
    ce_l <= ce_s1;
  end

  // pin synchronisers, idle level high
  always_ff @(posedge link_clk)
  begin
    if (lrst)
    begin
      {scl_s1, scl_s2, scl_s3} <= 3'h7;
      {sda_s1, sda_s2, sda_s3} <= 3'h7;
    end
    else if (ce_l)
    begin
      scl_s1 <= scl_i;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= sda_i;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
    end
  end

  // bus conditions seen from synchronised levels
  assign scl_rise = ce_l && scl_s2 && !scl_s3;
  assign scl_fall = ce_l && !scl_s2 && scl_s3;
  assign start_det = ce_l && scl_s2 && scl_s3 && sda_s3 && !sda_s2;
  assign stop_det = ce_l && scl_s2 && scl_s3 && !sda_s3 && sda_s2;
  assign rx_last = scl_fall && done_reg;

  // register events
  assign wr_evt = state_reg == MIR_WDATA && rx_last;
  assign soft_rst = wr_evt && ptr_reg == MIR_RESET_PTR_IRQ && shift_reg[MIR_SOFT_RST_BIT];
  assign load_rd = scl_fall && ((state_reg == MIR_ADDR_ACK && rw_reg) || (state_reg == MIR_RACK && master_acknowledge_reg));
  assign rd_ptr = (state_reg == MIR_ADDR_ACK) ? base_reg : ptr_reg;
  assign win_now = (state_reg == MIR_ADDR_ACK) ? (base_reg <= MIR_WRAP_LAST) : win_reg;
  assign rd_byte = mir_read(rd_ptr);
  assign axis_rd = load_rd && rd_ptr <= MIR_AXIS_LAST;
  assign sample_evt = ce_l && (req_s2 ^ req_s3);

  // protocol engine
  always_ff @(posedge link_clk)
  begin
    if (lrst)
    begin
      state_reg <= MIR_IDLE;
      cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      done_reg <= 1'b0;
      rw_reg <= 1'b0;
      master_acknowledge_reg <= 1'b0;
      oe_reg <= 1'b0;
    end
    else if (start_det)
    begin
      state_reg <= MIR_ADDR;
      cnt_reg <= 3'h0;
      done_reg <= 1'b0;
      oe_reg <= 1'b0;
    end
    else if (stop_det)
    begin
      state_reg <= MIR_IDLE;
      oe_reg <= 1'b0;
    end
    else if (ce_l)
    begin
      case (state_reg)
        MIR_ADDR, MIR_REG, MIR_WDATA:
        begin
          if (scl_rise)
          begin
            shift_reg <= {shift_reg[6:0], sda_s2};
            cnt_reg <= cnt_reg + 3'h1;
            done_reg <= cnt_reg == MIR_BIT_LAST;
          end
          else if (rx_last)
          begin
            done_reg <= 1'b0;
            if (state_reg == MIR_ADDR)
            begin
              // foreign address, stay off the bus
              if (shift_reg[7:1] == MIR_DEV_ADDR)
              begin
                oe_reg <= 1'b1;
                rw_reg <= shift_reg[0];
                state_reg <= MIR_ADDR_ACK;
              end
              else
                state_reg <= MIR_IDLE;
            end
            else
            begin
              oe_reg <= 1'b1;
              state_reg <= (state_reg == MIR_REG) ? MIR_REG_ACK : MIR_WDATA_ACK;
            end
          end
        end
        MIR_ADDR_ACK, MIR_RACK:
        begin
          if (scl_rise)
            master_acknowledge_reg <= !sda_s2;
          else if (load_rd)
          begin
            tx_reg <= rd_byte;
            oe_reg <= !rd_byte[7];
            cnt_reg <= 3'h0;
            state_reg <= MIR_RDATA;
          end
          else if (scl_fall)
          begin
            oe_reg <= 1'b0;
            cnt_reg <= 3'h0;
            state_reg <= (state_reg == MIR_ADDR_ACK) ? MIR_REG : MIR_IDLE;
          end
        end
        MIR_REG_ACK, MIR_WDATA_ACK:
        begin
          if (scl_fall)
          begin
            oe_reg <= 1'b0;
            cnt_reg <= 3'h0;
            state_reg <= MIR_WDATA;
          end
        end
        MIR_RDATA:
        begin
          if (scl_rise)
          begin
            cnt_reg <= cnt_reg + 3'h1;
            done_reg <= cnt_reg == MIR_BIT_LAST;
          end
          else if (rx_last)
          begin
            done_reg <= 1'b0;
            oe_reg <= 1'b0;
            state_reg <= MIR_RACK;
          end
          else if (scl_fall)
          begin
            tx_reg <= {tx_reg[6:0], 1'b0};
            oe_reg <= !tx_reg[6];
          end
        end
        default:
          state_reg <= MIR_IDLE;
      endcase
    end
  end

  // one 8-bit pointer selects a register
  always_ff @(posedge link_clk)
  begin
    if (lrst)
    begin
      ptr_reg <= MIR_PTR_RST;
      base_reg <= MIR_PTR_RST;
      win_reg <= 1'b0;
    end
    else if (state_reg == MIR_REG && rx_last)
    begin
      ptr_reg <= shift_reg;
      base_reg <= shift_reg;
    end
    else if (wr_evt)
      ptr_reg <= mir_next_ptr(ptr_reg, 1'b0);
    else if (load_rd)
    begin
      ptr_reg <= mir_next_ptr(rd_ptr, wrap_en_reg && win_now);
      win_reg <= win_now;
    end
  end

  // writable registers
  always_ff @(posedge link_clk)
  begin
    if (lrst || soft_rst)
    begin
      cfg_reg <= MIR_CFG_RST;
      wrap_en_reg <= 1'b0;
    end
    else if (wr_evt)
    begin
      case (ptr_reg)
        MIR_MEAS_CONFIG:
          {cfg_reg.oversample_ratio, cfg_reg.field_range, cfg_reg.output_rate, cfg_reg.mode} <= shift_reg;
        MIR_RESET_PTR_IRQ:
        begin
          wrap_en_reg <= shift_reg[MIR_WRAP_EN_BIT];
          cfg_reg.irq_pin_disable <= shift_reg[MIR_IRQ_DIS_BIT];
        end
        MIR_SR_PERIOD:
          cfg_reg.set_reset_period_value <= shift_reg;
        default:
          cfg_reg <= cfg_reg;
      endcase
    end
  end

  // measurement registers, flags and read lock
  always_ff @(posedge link_clk)
  begin
    if (lrst || soft_rst)
    begin
      data_reg <= MIR_MEAS_RST;
      data_ready_flag_reg <= 1'b0;
      data_overrun_flag_reg <= 1'b0;
      lock_reg <= 1'b0;
    end
    else if (ce_l)
    begin
      // lock from first axis read until 05 read
      if (axis_rd)
        lock_reg <= rd_ptr != MIR_AXIS_LAST;
      if (sample_evt)
      begin
        data_reg.temperature_value <= hold_reg.temperature_value;
        data_reg.overflow_flag <= hold_reg.overflow_flag;
        if (!lock_reg)
        begin
          data_reg.x_axis_field <= hold_reg.x_axis_field;
          data_reg.y_axis_field <= hold_reg.y_axis_field;
          data_reg.z_axis_field <= hold_reg.z_axis_field;
        end
        // a sample in the clearing cycle still sets the flags
        data_ready_flag_reg <= 1'b1;
        data_overrun_flag_reg <= lock_reg || data_ready_flag_reg || data_overrun_flag_reg;
      end
      else if (axis_rd)
      begin
        data_ready_flag_reg <= 1'b0;
        data_overrun_flag_reg <= 1'b0;
      end
    end
  end

  // data-ready pin gated by disable bit
  always_ff @(posedge link_clk)
  begin
    if (lrst)
      irq_reg <= 1'b0;
    else if (ce_l)
      irq_reg <= data_ready_flag_reg && !cfg_reg.irq_pin_disable;
  end

  // sample request toggle seen in the link domain
  always_ff @(posedge link_clk)
  begin
    if (lrst)
      {req_s1, req_s2, req_s3} <= 3'h0;
    else if (ce_l)
    begin
      req_s1 <= req_reg;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
    end
  end

  // core side: hold a sample until the link domain takes it
  assign meas_ready = req_reg == ack_s2;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      req_reg <= 1'b0;
      hold_reg <= MIR_MEAS_RST;
      {ack_s1, ack_s2} <= 2'h0;
    end
    else if (ce)
    begin
      ack_s1 <= req_s3;
      ack_s2 <= ack_s1;
      if (meas_valid && meas_ready)
      begin
        hold_reg <= meas;
        req_reg <= !req_reg;
      end
    end
  end

  // quasi-static configuration and pin level into the core domain
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cfg_s1 <= MIR_CFG_RST;
      cfg_s2 <= MIR_CFG_RST;
      cfg_s3 <= MIR_CFG_RST;
      cfg_out_reg <= MIR_CFG_RST;
      irq_s1 <= 1'b0;
      irq_s2 <= 1'b0;
    end
    else if (ce)
    begin
      cfg_s1 <= cfg_reg;
      cfg_s2 <= cfg_s1;
      cfg_s3 <= cfg_s2;
      // a word passes only once two samples agree, so a half-updated word never reaches the core
      if (cfg_s2 == cfg_s3)
        cfg_out_reg <= cfg_s3;
      irq_s1 <= irq_reg;
      irq_s2 <= irq_s1;
    end
  end

  assign cfg = cfg_out_reg;
  assign data_ready_pin = irq_s2;
  assign sda_o = 1'b0; // open drain, only ever pulls low
  assign sda_oe = oe_reg;

  // checks on the link domain
  property p_addr_ack;
    @(posedge link_clk) disable iff (lrst)
    (state_reg == MIR_ADDR && rx_last && !start_det && !stop_det && shift_reg[7:1] == MIR_DEV_ADDR)
      |=> (oe_reg && state_reg == MIR_ADDR_ACK);
  endproperty
  chk_addr_ack_drive: assert property (p_addr_ack) else $error("own address not acked");

  chk_ack_line_release: assert property (@(posedge link_clk) disable iff (lrst)
    (state_reg == MIR_REG_ACK && scl_fall && !start_det && !stop_det) |=> (!oe_reg && state_reg == MIR_WDATA))
    else $error("ack not released");

  chk_foreign_addr_quiet: assert property (@(posedge link_clk) disable iff (lrst)
    (state_reg == MIR_ADDR && rx_last && !start_det && !stop_det && shift_reg[7:1] != MIR_DEV_ADDR)
      |=> (!oe_reg && state_reg == MIR_IDLE) ##1 !oe_reg)
    else $error("foreign address touched bus");

  chk_ptr_load_value: assert property (@(posedge link_clk) disable iff (lrst)
    (state_reg == MIR_REG && rx_last) |=> (ptr_reg == $past(shift_reg) && base_reg == $past(shift_reg)))
    else $error("pointer not loaded");

  chk_period_store: assert property (@(posedge link_clk) disable iff (lrst)
    (wr_evt && ptr_reg == MIR_SR_PERIOD) |=> (cfg_reg.set_reset_period_value == $past(shift_reg)))
    else $error("period write lost");

  chk_read_start_base: assert property (@(posedge link_clk) disable iff (lrst)
    (state_reg == MIR_ADDR_ACK && load_rd && !start_det && !stop_det) |=> (tx_reg == $past(rd_byte)))
    else $error("read not at base pointer");

  chk_ptr_wrap_six: assert property (@(posedge link_clk) disable iff (lrst)
    (load_rd && wrap_en_reg && win_now && rd_ptr == MIR_WRAP_LAST) |=> ptr_reg == MIR_PTR_RST)
    else $error("pointer did not wrap");

  chk_nack_ends_read: assert property (@(posedge link_clk) disable iff (lrst)
    (state_reg == MIR_RACK && scl_fall && !master_acknowledge_reg && !start_det && !stop_det)
      |=> (!oe_reg && state_reg == MIR_IDLE))
    else $error("nack did not end read");

  chk_axis_read_clears: assert property (@(posedge link_clk) disable iff (lrst)
    (axis_rd && !sample_evt && !soft_rst) |=> (!data_ready_flag_reg && !data_overrun_flag_reg))
    else $error("flags not cleared");

  chk_lock_holds_data: assert property (@(posedge link_clk) disable iff (lrst)
    (lock_reg && sample_evt && !soft_rst) |=> ($stable(data_reg.x_axis_field) && data_overrun_flag_reg))
    else $error("locked data overwritten");

  chk_soft_reset_all: assert property (@(posedge link_clk) disable iff (lrst)
    soft_rst |=> (cfg_reg == MIR_CFG_RST && !wrap_en_reg && !data_ready_flag_reg && data_reg == MIR_MEAS_RST))
    else $error("soft reset incomplete");

  chk_irq_disable_pin: assert property (@(posedge link_clk) disable iff (lrst)
    (cfg_reg.irq_pin_disable && ce_l) |=> !irq_reg)
    else $error("pin not disabled");

  // main scenarios
  cov_write_byte: cover property (@(posedge link_clk) disable iff (lrst) wr_evt);
  cov_burst_read: cover property (@(posedge link_clk) disable iff (lrst)
    state_reg == MIR_RACK && load_rd);
  cov_wrap: cover property (@(posedge link_clk) disable iff (lrst)
    load_rd && wrap_en_reg && win_now && rd_ptr == MIR_WRAP_LAST);
  cov_overrun: cover property (@(posedge link_clk) disable iff (lrst) sample_evt && lock_reg);

endmodule : mir_i2c_regs

// file: rtl/mir_pkg.sv
package mir_pkg;

  // bus address of this device, seven bits
  localparam logic [6:0] MIR_DEV_ADDR = 7'h0d;

  // register offsets
  localparam logic [7:0] MIR_X_LOW = 8'h00;
  localparam logic [7:0] MIR_X_HIGH = 8'h01;
  localparam logic [7:0] MIR_Y_LOW = 8'h02;
  localparam logic [7:0] MIR_Y_HIGH = 8'h03;
  localparam logic [7:0] MIR_Z_LOW = 8'h04;
  localparam logic [7:0] MIR_Z_HIGH = 8'h05;
  localparam logic [7:0] MIR_STATUS = 8'h06;
  localparam logic [7:0] MIR_TEMP_LOW = 8'h07;
  localparam logic [7:0] MIR_TEMP_HIGH = 8'h08;
  localparam logic [7:0] MIR_MEAS_CONFIG = 8'h09;
  localparam logic [7:0] MIR_RESET_PTR_IRQ = 8'h0a;
  localparam logic [7:0] MIR_SR_PERIOD = 8'h0b;

  // last location of the wrap window and of the axis block
  localparam logic [7:0] MIR_WRAP_LAST = 8'h06;
  localparam logic [7:0] MIR_AXIS_LAST = 8'h05;

  // field positions in the reset/pointer/irq control register
  localparam int MIR_SOFT_RST_BIT = 7;
  localparam int MIR_WRAP_EN_BIT = 6;
  localparam int MIR_IRQ_DIS_BIT = 0;

  // bit count of a byte, minus one
  localparam logic [2:0] MIR_BIT_LAST = 3'h7;

  // measurement sample handed in by the sensor core
  typedef struct packed {
    logic [15:0] x_axis_field;
    logic [15:0] y_axis_field;
    logic [15:0] z_axis_field;
    logic [15:0] temperature_value;
    logic overflow_flag;
  } mir_meas_t;

  // configuration handed out to the sensor core
  typedef struct packed {
    logic [1:0] oversample_ratio;
    logic [1:0] field_range;
    logic [1:0] output_rate;
    logic [1:0] mode;
    logic [7:0] set_reset_period_value;
    logic irq_pin_disable;
  } mir_cfg_t;

  // values after reset
  localparam mir_cfg_t MIR_CFG_RST = '0;
  localparam mir_meas_t MIR_MEAS_RST = '0;
  localparam logic [7:0] MIR_PTR_RST = 8'h00;
  // core cycles over which rst is stretched for the slower link clock
  localparam logic [4:0] MIR_RST_HOLD = 5'h1f;

  // protocol engine states, gray coded along the write path
  typedef enum logic [3:0] {
    MIR_IDLE = 4'h0,
    MIR_ADDR = 4'h1,
    MIR_ADDR_ACK = 4'h3,
    MIR_REG = 4'h2,
    MIR_REG_ACK = 4'h6,
    MIR_WDATA = 4'h7,
    MIR_WDATA_ACK = 4'h5,
    MIR_RDATA = 4'h4,
    MIR_RACK = 4'hc
  } mir_state_t;

endpackage : mir_pkg

// file: verification/magnetometer_i2c_register_port_tb.sv
`timescale 1ns/100ps
// bench: random samples and settings with corner reads
module magnetometer_i2c_register_port_tb;
  import mir_pkg::*;
  logic clk;
  logic link_clk;
  logic rst;
  logic meas_valid;
  mir_meas_t meas;
  logic meas_ready;
  mir_cfg_t cfg;
  logic data_ready_pin;
  logic ce;
  logic sda_o;
  logic sda_oe;
  logic scl;
  logic m_oe;
  logic sda;
  logic k;
  logic [7:0] q [0:7];
  logic [7:0] st;
  logic [7:0] v;
  mir_meas_t sa;
  mir_meas_t sb;
  int p;
  int n_mismatch;
  int cmp_count;

  // wired-and data line with pull-up
  assign sda = !(m_oe || (sda_oe && !sda_o));

  // core and link clocks, unrelated in phase
  initial
  begin
    clk = 1'b0;
    forever #5 clk = !clk;
  end
  initial
  begin
    link_clk = 1'b0;
    #3.7;
    forever #32 link_clk = !link_clk;
  end

  mir_i2c_regs i_mir_i2c_regs (.clk(clk), .rst(rst), .ce(ce), .link_clk(link_clk), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .meas_valid(meas_valid), .meas(meas),
    .meas_ready(meas_ready), .cfg(cfg), .data_ready_pin(data_ready_pin));
  mir_i2c_master i_mir_i2c_master (.clk(clk), .sda_i(sda), .scl(scl), .sda_oe(m_oe));

  // compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one-register write transfer
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    i_mir_i2c_master.start();
    i_mir_i2c_master.tx({MIR_DEV_ADDR, 1'b0}, k);
    chk({7'h00, k}, 8'h00);
    i_mir_i2c_master.tx(a, k);
    chk({7'h00, k}, 8'h00);
    i_mir_i2c_master.tx(d, k);
    chk({7'h00, k}, 8'h00);
    i_mir_i2c_master.stop();
  endtask : wreg

  // burst read of n bytes, optionally after a pointer write phase
  task automatic rd(input logic [7:0] a, input int n, input logic setp);
    if (setp)
    begin
      i_mir_i2c_master.start();
      i_mir_i2c_master.tx({MIR_DEV_ADDR, 1'b0}, k);
      i_mir_i2c_master.tx(a, k);
    end
    i_mir_i2c_master.start();
    i_mir_i2c_master.tx({MIR_DEV_ADDR, 1'b1}, k);
    chk({7'h00, k}, 8'h00);
    for (int i = 0; i < n; i++)
    begin
      i_mir_i2c_master.rx(i == n - 1, q[i]);
    end
    i_mir_i2c_master.stop();
  endtask : rd

  // hand a sample to the port and let it cross
  task automatic send(input mir_meas_t m);
    int t;
    t = 0;
    @(negedge clk);
    while (!meas_ready && t < 100)
    begin
      @(negedge clk);
      t++;
    end
    @(posedge clk);
    meas <= m;
    meas_valid <= 1'b1;
    @(posedge clk);
    meas_valid <= 1'b0;
    repeat (100) @(posedge clk);
  endtask : send

  // expected byte of a data register (00..05 axes, 07..08 temperature)
  function automatic logic [7:0] axis_b(input mir_meas_t m, input int a);
    logic [15:0] w;
    int o;
    o = (a > 6) ? a - 1 : a;
    case (o / 2)
      0: w = m.x_axis_field;
      1: w = m.y_axis_field;
      2: w = m.z_axis_field;
      default: w = m.temperature_value;
    endcase
    return o[0] ? w[15:8] : w[7:0];
  endfunction : axis_b

  // expected next pointer, wrapping from 06 when enabled
  function automatic int nxt(input int a, input logic wr);
    return (wr && a == 6) ? 0 : a + 1;
  endfunction : nxt

  // verdict and end of run
  task automatic print_verdict();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict

  // watchdog against a hung transfer
  initial
  begin
    #1000000;
    n_mismatch++;
    print_verdict();
  end

  // main sequence
  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    meas_valid = 1'b0;
    meas = '0;
    n_mismatch = 0;
    cmp_count = 0;
    v = 8'($urandom(32'hecab4cd0));
    sa = {32'($urandom), 32'($urandom), 1'($urandom)};
    sb = {32'($urandom), 32'($urandom), 1'($urandom)};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (60) @(posedge clk);
    // defaults, then random settings read back
    rd(MIR_MEAS_CONFIG, 3, 1'b1);
    for (int i = 0; i < 3; i++)
      chk(q[i], 8'h00);
    wreg(MIR_SR_PERIOD, v);
    wreg(MIR_MEAS_CONFIG, ~v);
    rd(MIR_MEAS_CONFIG, 3, 1'b1);
    chk(q[0], ~v);
    chk(q[2], v);
    chk(cfg.set_reset_period_value, v);
    chk({cfg.oversample_ratio, cfg.field_range, cfg.output_rate, cfg.mode}, ~v);
    // read-only places and unused bits
    wreg(MIR_RESET_PTR_IRQ, 8'h7f);
    wreg(MIR_STATUS, 8'hff);
    wreg(8'h0c, 8'hff);
    rd(MIR_RESET_PTR_IRQ, 3, 1'b1);
    chk(q[0], 8'h41);
    chk(q[2], 8'h00);
    rd(MIR_STATUS, 1, 1'b1);
    chk(q[0], 8'h00);
    chk({7'h00, cfg.irq_pin_disable}, 8'h01);
    // pin enabled, wrap on, first sample
    wreg(MIR_RESET_PTR_IRQ, 8'h40);
    send(sa);
    chk({7'h00, data_ready_pin}, 8'h01);
    rd(MIR_STATUS, 1, 1'b1);
    chk(q[0], {6'h00, sa.overflow_flag, 1'b1});
    // wrap burst from the z high byte: 05 06 00 01
    rd(MIR_Z_HIGH, 4, 1'b1);
    st = {6'h00, sa.overflow_flag, 1'b0};
    p = 5;
    for (int i = 0; i < 4; i++)
    begin
      chk(q[i], (p == 6) ? st : axis_b(sa, p));
      p = nxt(p, 1'b1);
    end
    chk({7'h00, data_ready_pin}, 8'h00);
    // locked by the 00/01 reads: axes of the second sample must not land
    send(sb);
    rd(MIR_STATUS, 1, 1'b1);
    chk(q[0], {5'h00, 1'b1, sb.overflow_flag, 1'b1});
    wreg(MIR_RESET_PTR_IRQ, 8'h00);
    rd(MIR_X_LOW, 8, 1'b1);
    for (int i = 0; i < 6; i++)
      chk(q[i], axis_b(sa, i));
    chk(q[6], {6'h00, sb.overflow_flag, 1'b0});
    chk(q[7], axis_b(sb, 7));
    // read without a write phase starts again at the last pointer written
    rd(8'h00, 1, 1'b0);
    chk(q[0], axis_b(sa, 0));
    // foreign address gets no ack
    i_mir_i2c_master.start();
    i_mir_i2c_master.tx({MIR_DEV_ADDR + 7'h01, 1'b0}, k);
    chk({7'h00, k}, 8'h01);
    i_mir_i2c_master.stop();
    // frozen port stays off the bus even for its own address
    ce <= 1'b0;
    repeat (40) @(posedge clk);
    i_mir_i2c_master.start();
    i_mir_i2c_master.tx({MIR_DEV_ADDR, 1'b0}, k);
    chk({7'h00, k}, 8'h01);
    i_mir_i2c_master.stop();
    ce <= 1'b1;
    repeat (40) @(posedge clk);
    // soft reset
    wreg(MIR_RESET_PTR_IRQ, 8'h80);
    rd(MIR_MEAS_CONFIG, 3, 1'b1);
    for (int i = 0; i < 3; i++)
      chk(q[i], 8'h00);
    chk(cfg.set_reset_period_value, 8'h00);
    chk({6'h00, cfg.mode}, 8'h00);
    print_verdict();
  end
endmodule : magnetometer_i2c_register_port_tb

// file: verification/mir_i2c_master.sv
`timescale 1ns/100ps
// bit-banged bus master, data line open drain
module mir_i2c_master (
  // bench clock
  input wire logic clk,
  // bus lines
  input wire logic sda_i,
  output logic scl,
  output logic sda_oe
);
  // quarter bus period in core cycles, keeps data hold above three link cycles
  localparam int QTR = 20;

  // idle bus: clock high, data released
  initial
  begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end

  // wait a quarter period
  task automatic qw();
    repeat (QTR) @(posedge clk);
  endtask : qw

  // start or repeated start, data falls while clock high
  // start framing
  task automatic start();
    qw();
    sda_oe <= 1'b0;
    qw();
    scl <= 1'b1;
    qw();
    sda_oe <= 1'b1;
    qw();
    scl <= 1'b0;
  endtask : start

  // one bit: data set in low phase, sampled in mid high phase
  task automatic bitx(input logic b, output logic r);
    qw();
    sda_oe <= !b;
    qw();
    scl <= 1'b1;
    qw();
    r = sda_i;
    qw();
    scl <= 1'b0;
  endtask : bitx

  // stop, data rises while clock high
  // stop after ack
  task automatic stop();
    qw();
    sda_oe <= 1'b1;
    qw();
    scl <= 1'b1;
    qw();
    sda_oe <= 1'b0;
    qw();
  endtask : stop

  // send a byte msb first, then sample the device ack
  // address, register and data bytes
  task automatic tx(input logic [7:0] d, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bitx(d[i], r);
    end
    bitx(1'b1, a);
  endtask : tx

  // receive a byte with the line released, then ack or nack
  // master acknowledge
  task automatic rx(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bitx(1'b1, d[i]);
    end
    bitx(nack, r);
  endtask : rx
endmodule : mir_i2c_master
